// [rtl/imrt_top.sv]
// Two-wire master: repeated start generation and byte transmission
`timescale 1ns/100ps
`default_nettype none

module imrt_top (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic restart_request_set_i,
  input wire logic shift_buffer_port_wr_i,
  input wire logic [7:0] shift_buffer_port_data_i,
  input wire logic [7:0] rate_reload_value_i,
  input wire logic serial_port_irq_flag_clr_i,
  input wire logic write_collision_flag_clr_i,
  input wire logic bus_collision_flag_clr_i,
  output logic restart_request_o,
  output logic buffer_full_flag_o,
  output logic write_collision_flag_o,
  output logic ack_received_status_o,
  output logic serial_port_irq_flag_o,
  output logic bus_collision_flag_o,
  output logic start_seen_o,
  output logic busy_o,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  output logic sda_o,
  output logic sda_oe_n_o
);
  import imrt_pkg::*;

  // ----------------------------------------------------------------
  // Software domain: command handshake and sticky flags
  // ----------------------------------------------------------------
  imrt_cmd_t cmd_q, cmd_d;
  logic req_tgl_q;
  logic pend_q;
  logic [IMRT_SYNC_N-1:0] ack_sync_q, done_sync_q, bcol_sync_q;
  logic ack_seen_q, done_seen_q, bcol_seen_q;
  imrt_stat_t st_s1_q, st_s2_q;
  logic irq_q, write_collision_flag_q, bcol_q;
  logic lk_ack_tgl_q, lk_done_tgl_q, lk_bcol_tgl_q;
  imrt_stat_t lk_stat_q;

  wire ack_evt = ack_sync_q[IMRT_SYNC_N-1] ^ ack_seen_q;
  wire done_evt = done_sync_q[IMRT_SYNC_N-1] ^ done_seen_q;
  wire bcol_evt = bcol_sync_q[IMRT_SYNC_N-1] ^ bcol_seen_q;
  wire pend_now = pend_q & ~ack_evt;
  wire sw_busy = pend_q | st_s2_q.busy;
  wire wr_take = shift_buffer_port_wr_i & ~sw_busy;
  wire rs_take = restart_request_set_i & ~sw_busy & ~shift_buffer_port_wr_i;
  // write while busy is a collision
  wire write_collision_flag_set = shift_buffer_port_wr_i & sw_busy;
  wire cmd_take = wr_take | rs_take;

  always_comb begin
    cmd_d = cmd_q;
    if (cmd_take) begin
      cmd_d.is_write = wr_take;
      cmd_d.data = wr_take ? shift_buffer_port_data_i : cmd_q.data;
      cmd_d.reload = rate_reload_value_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cmd_q <= IMRT_CMD_RST;
      req_tgl_q <= 1'b0;
      pend_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      req_tgl_q <= req_tgl_q ^ cmd_take;
      pend_q <= cmd_take | pend_now;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_sync_q <= '0;
      done_sync_q <= '0;
      bcol_sync_q <= '0;
      ack_seen_q <= 1'b0;
      done_seen_q <= 1'b0;
      bcol_seen_q <= 1'b0;
      st_s1_q <= IMRT_STAT_RST;
      st_s2_q <= IMRT_STAT_RST;
    end else begin
      ack_sync_q <= {ack_sync_q[IMRT_SYNC_N-2:0], lk_ack_tgl_q};
      done_sync_q <= {done_sync_q[IMRT_SYNC_N-2:0], lk_done_tgl_q};
      bcol_sync_q <= {bcol_sync_q[IMRT_SYNC_N-2:0], lk_bcol_tgl_q};
      ack_seen_q <= ack_sync_q[IMRT_SYNC_N-1];
      done_seen_q <= done_sync_q[IMRT_SYNC_N-1];
      bcol_seen_q <= bcol_sync_q[IMRT_SYNC_N-1];
      st_s1_q <= lk_stat_q;
      st_s2_q <= st_s1_q;
    end
  end

  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
      bcol_q <= 1'b0;
    end else begin
      irq_q <= done_evt | (irq_q & ~serial_port_irq_flag_clr_i);
      // only software clears the write collision flag
      write_collision_flag_q <= write_collision_flag_set | (write_collision_flag_q & ~write_collision_flag_clr_i);
      bcol_q <= bcol_evt | (bcol_q & ~bus_collision_flag_clr_i);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      restart_request_o <= 1'b0;
      buffer_full_flag_o <= 1'b0;
      write_collision_flag_o <= 1'b0;
      ack_received_status_o <= 1'b0;
      serial_port_irq_flag_o <= 1'b0;
      bus_collision_flag_o <= 1'b0;
      start_seen_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      restart_request_o <= (pend_now & ~cmd_q.is_write) | st_s2_q.rs_active;
      // full flag shows from the accepted write onward
      buffer_full_flag_o <= (pend_now & cmd_q.is_write) | st_s2_q.buf_full;
      write_collision_flag_o <= write_collision_flag_q;
      ack_received_status_o <= st_s2_q.ack_stat;
      serial_port_irq_flag_o <= irq_q;
      bus_collision_flag_o <= bcol_q;
      start_seen_o <= st_s2_q.start_seen;
      busy_o <= pend_now | st_s2_q.busy;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: pin sampling and command pickup
  // ----------------------------------------------------------------
  logic [IMRT_SYNC_N-1:0] scl_sync_q, sda_sync_q, req_sync_q;
  logic req_seen_q, sda_prev_q, scl_prev_q;

  wire scl_s = scl_sync_q[IMRT_SYNC_N-1];
  wire sda_s = sda_sync_q[IMRT_SYNC_N-1];
  wire req_evt = req_sync_q[IMRT_SYNC_N-1] ^ req_seen_q;

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_sync_q <= '1;
      sda_sync_q <= '1;
      req_sync_q <= '0;
      req_seen_q <= 1'b0;
      sda_prev_q <= 1'b1;
      scl_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[IMRT_SYNC_N-2:0], scl_i};
      sda_sync_q <= {sda_sync_q[IMRT_SYNC_N-2:0], sda_i};
      req_sync_q <= {req_sync_q[IMRT_SYNC_N-2:0], req_tgl_q};
      req_seen_q <= req_sync_q[IMRT_SYNC_N-1];
      sda_prev_q <= sda_s;
      scl_prev_q <= scl_s;
    end
  end

  // start pattern seen on the lines, cleared by a stop pattern
  wire start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------------------------------
  // Link domain: bit period counter and bus engine
  // ----------------------------------------------------------------
  imrt_state_t state_q, state_d;
  logic [7:0] cnt_q, cnt_d, reload_q;
  logic run_q, run_d;
  logic [7:0] sreg_q, sreg_d;
  logic [3:0] bit_q, bit_d;
  logic drv_scl_q, drv_scl_d, drv_sda_q, drv_sda_d;
  logic bf_q, bf_d, ack_q, ack_d;
  logic done_ev, bcol_ev;

  wire tmo = run_q & (cnt_q == IMRT_CNT_ZERO);
  wire idle = (state_q == IMRT_IDLE);
  // the engine itself also refuses anything while active
  wire take_wr = req_evt & idle & cmd_q.is_write;
  wire take_rs = req_evt & idle & ~cmd_q.is_write;
  wire last_bit = (bit_q == IMRT_BIT_ACK);
  wire [3:0] bit_nx = bit_q + IMRT_BIT_STEP;

  always_comb begin
    state_d = state_q;
    cnt_d = run_q ? cnt_q - IMRT_CNT_STEP : cnt_q;
    run_d = run_q;
    sreg_d = sreg_q;
    bit_d = bit_q;
    drv_scl_d = drv_scl_q;
    drv_sda_d = drv_sda_q;
    bf_d = bf_q;
    ack_d = ack_q;
    done_ev = 1'b0;
    bcol_ev = 1'b0;
    case (state_q)
      IMRT_IDLE: begin
        run_d = 1'b0;
        if (take_wr) begin
          // accepted write loads the shifter and starts the byte
          sreg_d = cmd_q.data;
          bit_d = IMRT_BIT_FIRST;
          bf_d = 1'b1;
          drv_scl_d = 1'b1;
          state_d = IMRT_TX_LOW;
        end else if (take_rs) begin
          drv_scl_d = 1'b1;
          state_d = IMRT_RS_LOW;
        end
      end
      IMRT_RS_LOW: begin
        if (!run_q && !scl_s) begin
          drv_sda_d = 1'b0;
          cnt_d = reload_q;
          run_d = 1'b1;
        end else if (tmo) begin
          run_d = 1'b0;
          if (sda_s) begin
            drv_scl_d = 1'b0;
            state_d = IMRT_RS_REL;
          end else begin
            bcol_ev = 1'b1;
          end
        end
      end
      IMRT_RS_REL: begin
        // counter stays suspended until SCL reads high
        run_d = 1'b0;
        if (scl_s) begin
          // SDA low at SCL rise is a collision
          if (!sda_s) begin
            bcol_ev = 1'b1;
          end else begin
            // SCL must stay high for one period, SDA is not rechecked
            cnt_d = reload_q;
            run_d = 1'b1;
            state_d = IMRT_RS_HIGH;
          end
        end
      end
      IMRT_RS_HIGH: begin
        // SCL pulled low before SDA driven low
        if (!scl_s) begin
          bcol_ev = 1'b1;
        end else if (tmo) begin
          drv_sda_d = 1'b1;
          cnt_d = reload_q;
          state_d = IMRT_RS_SDA;
        end
      end
      IMRT_RS_SDA: begin
        // SDA low period doubles as the start hold time
        if (tmo) begin
          // end with SCL low, SDA held, no reload
          drv_scl_d = 1'b1;
          run_d = 1'b0;
          // completion raises the interrupt only after timeout
          done_ev = 1'b1;
          state_d = IMRT_IDLE;
        end
      end
      IMRT_TX_LOW: begin
        if (!run_q && !scl_s) begin
          // bit goes out only once SCL reads low
          // ninth bit time leaves SDA released for the slave
          drv_sda_d = last_bit ? 1'b0 : ~sreg_q[IMRT_MSB];
          cnt_d = reload_q;
          run_d = 1'b1;
        end else if (tmo) begin
          run_d = 1'b0;
          drv_scl_d = 1'b0;
          state_d = IMRT_TX_REL;
        end
      end
      IMRT_TX_REL: begin
        // wait for the clock to really rise
        run_d = 1'b0;
        if (scl_s) begin
          // acknowledge captured at the ninth rising edge
          if (last_bit) begin
            ack_d = sda_s;
          end
          cnt_d = reload_q;
          run_d = 1'b1;
          state_d = IMRT_TX_HIGH;
        end
      end
      IMRT_TX_HIGH: begin
        // SDA is not touched in this state nor at the fall
        if (tmo) begin
          drv_scl_d = 1'b1;
          run_d = 1'b0;
          if (last_bit) begin
            // byte done, clock held low until the next write or restart
            done_ev = 1'b1;
            state_d = IMRT_IDLE;
          end else begin
            // eight bits, one per falling edge
            sreg_d = {sreg_q[IMRT_MSB-1:0], 1'b0};
            bit_d = bit_nx;
            if (bit_nx == IMRT_BIT_ACK) begin
              bf_d = 1'b0;
            end
            state_d = IMRT_TX_LOW;
          end
        end
      end
      default: begin
        state_d = IMRT_IDLE;
      end
    endcase
    // abort, release both lines, drop the request
    if (bcol_ev) begin
      drv_scl_d = 1'b0;
      drv_sda_d = 1'b0;
      bf_d = 1'b0;
      run_d = 1'b0;
      state_d = IMRT_IDLE;
    end
  end

  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= IMRT_IDLE;
      cnt_q <= IMRT_CNT_ZERO;
      run_q <= 1'b0;
      sreg_q <= IMRT_BYTE_ZERO;
      bit_q <= IMRT_BIT_FIRST;
      drv_scl_q <= 1'b0;
      drv_sda_q <= 1'b0;
      bf_q <= 1'b0;
      ack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      run_q <= run_d;
      sreg_q <= sreg_d;
      bit_q <= bit_d;
      drv_scl_q <= drv_scl_d;
      drv_sda_q <= drv_sda_d;
      bf_q <= bf_d;
      ack_q <= ack_d;
    end
  end

  // each reload takes the value latched with the command
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reload_q <= IMRT_CNT_ZERO;
    end else if (req_evt) begin
      reload_q <= cmd_q.reload;
    end
  end

  // Status levels and event toggles back to the software domain
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lk_ack_tgl_q <= 1'b0;
      lk_done_tgl_q <= 1'b0;
      lk_bcol_tgl_q <= 1'b0;
      lk_stat_q <= IMRT_STAT_RST;
    end else begin
      lk_ack_tgl_q <= lk_ack_tgl_q ^ req_evt;
      lk_done_tgl_q <= lk_done_tgl_q ^ done_ev;
      lk_bcol_tgl_q <= lk_bcol_tgl_q ^ bcol_ev;
      lk_stat_q.busy <= (state_d != IMRT_IDLE);
      lk_stat_q.buf_full <= bf_d;
      lk_stat_q.ack_stat <= ack_d;
      lk_stat_q.start_seen <= start_det | (lk_stat_q.start_seen & ~stop_det);
      lk_stat_q.rs_active <= (state_d == IMRT_RS_LOW) | (state_d == IMRT_RS_REL) |
                             (state_d == IMRT_RS_HIGH) | (state_d == IMRT_RS_SDA);
    end
  end

  // Open drain pins: output level is always low, enable low means driving
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_oe_n_o <= 1'b1;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n_o <= ~drv_scl_d;
      sda_oe_n_o <= ~drv_sda_d;
    end
  end

endmodule

`default_nettype wire

// [rtl/imrt_pkg.sv]
// Shared types and constants for the two-wire master restart and transmit block
package imrt_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int unsigned IMRT_DATA_W = 8;
  localparam int unsigned IMRT_SYNC_N = 2;
  localparam logic [3:0] IMRT_BIT_FIRST = 4'h0;
  localparam logic [3:0] IMRT_BIT_ACK = 4'h8;
  localparam logic [3:0] IMRT_BIT_STEP = 4'h1;
  localparam int unsigned IMRT_MSB = 7;
  localparam logic [7:0] IMRT_CNT_ZERO = 8'h00;
  localparam logic [7:0] IMRT_CNT_STEP = 8'h01;
  localparam logic [7:0] IMRT_BYTE_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Bus engine states, Gray on the forward steps; returns to IMRT_TX_LOW and IMRT_IDLE change more bits
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    IMRT_IDLE    = 4'h0,
    IMRT_RS_LOW  = 4'h1,
    IMRT_RS_REL  = 4'h3,
    IMRT_RS_HIGH = 4'h2,
    IMRT_RS_SDA  = 4'h6,
    IMRT_TX_LOW  = 4'h4,
    IMRT_TX_REL  = 4'h5,
    IMRT_TX_HIGH = 4'h7
  } imrt_state_t;

  // Command handed from the software domain to the bus engine
  typedef struct packed {
    logic is_write;
    logic [7:0] data;
    logic [7:0] reload;
  } imrt_cmd_t;

  // Levels handed from the bus engine back to the software domain
  typedef struct packed {
    logic busy;
    logic buf_full;
    logic ack_stat;
    logic start_seen;
    logic rs_active;
  } imrt_stat_t;

  localparam imrt_cmd_t IMRT_CMD_RST = '{is_write: 1'b0, data: 8'h00, reload: 8'h00};
  localparam imrt_stat_t IMRT_STAT_RST = '{busy: 1'b0, buf_full: 1'b0, ack_stat: 1'b0,
                                           start_seen: 1'b0, rs_active: 1'b0};

endpackage

// [verification/imrt_checker.sv]
// Port-level assertions for the restart and transmit block
`timescale 1ns/100ps
`default_nettype none
module imrt_checker (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic link_clk_i,
  input wire logic restart_request_set_i,
  input wire logic shift_buffer_port_wr_i,
  input wire logic write_collision_flag_clr_i,
  input wire logic restart_request_o,
  input wire logic buffer_full_flag_o,
  input wire logic write_collision_flag_o,
  input wire logic serial_port_irq_flag_o,
  input wire logic bus_collision_flag_o,
  input wire logic start_seen_o,
  input wire logic busy_o,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic scl_oe_n_o,
  input wire logic sda_oe_n_o
);
  AST_RS_IGNORED: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    restart_request_set_i && busy_o && !restart_request_o |=> !restart_request_o)
    else $error("restart accepted while busy");
  AST_BF_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    shift_buffer_port_wr_i && !busy_o |-> ##2 buffer_full_flag_o && busy_o)
    else $error("idle write did not set full flag");
  AST_WRITE_COLLISION_FLAG_SET: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    shift_buffer_port_wr_i && busy_o |-> ##[1:2] write_collision_flag_o)
    else $error("busy write did not flag collision");
  AST_WRITE_COLLISION_FLAG_KEPT: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    write_collision_flag_o && !write_collision_flag_clr_i && !$past(write_collision_flag_clr_i)
    |=> write_collision_flag_o)
    else $error("write collision flag cleared by itself");
  AST_RS_SCL_LOW: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(restart_request_o) |-> ##[1:24] !scl_oe_n_o)
    else $error("restart did not drive clock low");
  AST_RS_DONE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $fell(restart_request_o) && !scl_oe_n_o |-> !sda_oe_n_o ##[0:6] serial_port_irq_flag_o)
    else $error("restart end state wrong");
  AST_COLL_REL: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $rose(bus_collision_flag_o) |-> ##[0:4] (scl_oe_n_o && sda_oe_n_o && !restart_request_o))
    else $error("collision did not release the bus");
  AST_START_SEEN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    $fell(sda_i) && scl_i |-> ##[1:24] start_seen_o)
    else $error("start pattern not flagged");
  AST_SCL_LOW_T: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    $fell(scl_oe_n_o) |-> !scl_oe_n_o [*4])
    else $error("clock low period too short");
  // high period counted from the seen rise
  AST_SCL_HIGH_T: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    $rose(scl_i) && scl_oe_n_o |-> scl_oe_n_o [*4])
    else $error("clock high period too short");
  AST_SDA_STABLE: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    scl_oe_n_o && $past(scl_oe_n_o) && !restart_request_o |-> $stable(sda_oe_n_o))
    else $error("data moved while clock released");
  COV_RS_DONE: cover property (@(posedge ref_clk_i) $fell(restart_request_o) && !scl_oe_n_o);
  COV_WRITE_COLLISION_FLAG: cover property (@(posedge ref_clk_i) $rose(write_collision_flag_o));
  COV_COLL: cover property (@(posedge ref_clk_i) $rose(bus_collision_flag_o));
endmodule
bind imrt_top imrt_checker u_chk (.ref_clk_i, .reset_n_i, .link_clk_i, .restart_request_set_i,
  .shift_buffer_port_wr_i, .write_collision_flag_clr_i, .restart_request_o,
  .buffer_full_flag_o, .write_collision_flag_o, .serial_port_irq_flag_o,
  .bus_collision_flag_o, .start_seen_o, .busy_o, .scl_i, .sda_i, .scl_oe_n_o, .sda_oe_n_o);
`default_nettype wire

// [verification/imrt_target_model.sv]
// Behavioural two-wire target: byte capture, acknowledge and clock stretching
`timescale 1ns/100ps
`default_nettype none
module imrt_target_model (
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic ack_en_i,
  input wire logic sda_hold_low_i,
  input wire logic [3:0] stretch_i,
  output logic scl_low_o,
  output logic sda_low_o,
  output logic [7:0] rx_byte_o
);
  logic ack_low = 1'b0;
  int bit_cnt = 0;
  initial scl_low_o = 1'b0;
  initial rx_byte_o = 8'h00;
  // Held low on command to provoke a collision
  assign sda_low_o = ack_low | sda_hold_low_i;
  // Start pattern realigns the byte counter
  always @(negedge sda_i) if (scl_i) bit_cnt = 0;
  always @(posedge scl_i) begin
    // first bit lands at the top
    if (bit_cnt < 8) rx_byte_o = {rx_byte_o[6:0], sda_i};
    bit_cnt = bit_cnt + 1;
  end
  always @(negedge scl_i) begin
    ack_low = (bit_cnt == 8) && ack_en_i;
    if (bit_cnt == 9) bit_cnt = 0;
    if (stretch_i != 4'h0) begin
      scl_low_o = 1'b1;
      repeat (stretch_i) @(posedge link_clk_i);
      scl_low_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the restart and transmit block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic ref_clk, link_clk, rst_n, rs_set, wr, irq_clr, write_collision_flag_clr, bcl_clr;
  logic ack_en, hold_low, rs_req, bf, write_collision_flag, ack, irq, bcl, seen, busy;
  logic scl_oe_n, sda_oe_n, s_scl_low, s_sda_low, scl_lv, sda_lv;
  logic [7:0] data, reload, rx;
  logic [3:0] stretch;
  wire scl;
  wire sda;
  int fails = 0;
  int checked = 0;
  // Pull-ups: a released line reads high
  assign scl = (scl_oe_n | scl_lv) & ~s_scl_low;
  assign sda = (sda_oe_n | sda_lv) & ~s_sda_low;
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  imrt_top dut (.ref_clk_i(ref_clk), .reset_n_i(rst_n), .link_clk_i(link_clk),
    .restart_request_set_i(rs_set), .shift_buffer_port_wr_i(wr),
    .shift_buffer_port_data_i(data), .rate_reload_value_i(reload),
    .serial_port_irq_flag_clr_i(irq_clr), .write_collision_flag_clr_i(write_collision_flag_clr),
    .bus_collision_flag_clr_i(bcl_clr), .restart_request_o(rs_req), .buffer_full_flag_o(bf),
    .write_collision_flag_o(write_collision_flag), .ack_received_status_o(ack), .serial_port_irq_flag_o(irq),
    .bus_collision_flag_o(bcl), .start_seen_o(seen), .busy_o(busy), .scl_i(scl), .sda_i(sda),
    .scl_o(scl_lv), .scl_oe_n_o(scl_oe_n), .sda_o(sda_lv), .sda_oe_n_o(sda_oe_n));
  imrt_target_model u_target (.link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
    .ack_en_i(ack_en), .sda_hold_low_i(hold_low), .stretch_i(stretch),
    .scl_low_o(s_scl_low), .sda_low_o(s_sda_low), .rx_byte_o(rx));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // One-cycle pulse on {restart, write, irq clear, write_collision_flag clear, bcl clear}
  task strobe(input logic [4:0] m, input logic [7:0] d);
    @(posedge ref_clk);
    {rs_set, wr, irq_clr, write_collision_flag_clr, bcl_clr} <= m;
    data <= d;
    @(posedge ref_clk);
    {rs_set, wr, irq_clr, write_collision_flag_clr, bcl_clr} <= 5'h00;
  endtask
  task wait_evt;
    for (int i = 0; i < 3000; i++) begin
      if ((irq | bcl) === 1'b1) break;
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    chk("evt", 8'h01, {7'h00, irq | bcl});
  endtask
  task restart;
    strobe(5'h10, 8'h00);
    wait_evt;
    chk("irq", 8'h01, {7'h00, irq});
    chk("rs_req", 8'h00, {7'h00, rs_req});
    chk("seen", 8'h01, {7'h00, seen});
    chk("lines", 8'h00, {6'h00, scl_oe_n, sda_oe_n});
    strobe(5'h04, 8'h00);
    $display("test restart done");
  endtask
  task xfer(input logic [7:0] b, input logic nack, input logic poke);
    strobe(5'h08, b);
    repeat (2) @(negedge ref_clk);
    chk("bf", 8'h01, {7'h00, bf});
    if (poke) begin
      strobe(5'h08, ~b);
      repeat (2) @(negedge ref_clk);
      chk("write_collision_flag", 8'h01, {7'h00, write_collision_flag});
      strobe(5'h10, 8'h00);
      repeat (2) @(negedge ref_clk);
      chk("rs_req", 8'h00, {7'h00, rs_req});
    end
    wait_evt;
    chk("rx", b, rx);
    chk("ack", {7'h00, nack}, {7'h00, ack});
    chk("bf", 8'h00, {7'h00, bf});
    chk("scl_oe_n", 8'h00, {7'h00, scl_oe_n});
    strobe(5'h04, 8'h00);
    $display("test byte %h done", b);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under this
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    test_done;
  end
  initial begin
    rst_n = 1'b0;
    {rs_set, wr, irq_clr, write_collision_flag_clr, bcl_clr} = 5'h00;
    data = 8'h00;
    reload = 8'h02;
    ack_en = 1'b1;
    hold_low = 1'b0;
    stretch = 4'h0;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    chk("busy", 8'h00, {7'h00, busy});
    chk("oe_n", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    repeat (4) @(posedge ref_clk);
    restart;
    xfer(8'ha4, 1'b0, 1'b1);
    // Slow target that refuses the byte, longer bit period
    ack_en <= 1'b0;
    stretch <= 4'hc;
    reload <= 8'h04;
    xfer(8'h81, 1'b1, 1'b0);
    chk("write_collision_flag", 8'h01, {7'h00, write_collision_flag});
    strobe(5'h02, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("write_collision_flag", 8'h00, {7'h00, write_collision_flag});
    ack_en <= 1'b1;
    stretch <= 4'h0;
    restart;
    xfer(8'h5b, 1'b0, 1'b0);
    // Data line held low by another party during the restart
    hold_low <= 1'b1;
    strobe(5'h10, 8'h00);
    wait_evt;
    chk("bcl", 8'h01, {7'h00, bcl});
    chk("rs_req", 8'h00, {7'h00, rs_req});
    chk("irq", 8'h00, {7'h00, irq});
    chk("lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    hold_low <= 1'b0;
    strobe(5'h01, 8'h00);
    repeat (2) @(negedge ref_clk);
    chk("bcl", 8'h00, {7'h00, bcl});
    $display("test collision done");
    test_done;
  end
endmodule
`default_nettype wire
